// [hdl/phx_regs.svh]
// Purpose: Addresses, field positions, reset values and timing for the 10BT ops / ext control block
// Assumes: 16-bit management registers, 10 MHz system clock
// Notes: Definitions only
`ifndef PHX_REGS_SVH
`define PHX_REGS_SVH

// Management register addresses
`define PHX_OPS_ADDR 5'h12
`define PHX_EXT_ADDR 5'h13

// Operations register fields
`define PHX_OPS_RJAB 15
`define PHX_OPS_POL 14
`define PHX_OPS_JAB_INH 5
`define PHX_OPS_APOL_INH 3
`define PHX_OPS_SQE_INH 2
`define PHX_OPS_LINK_INH 1
`define PHX_OPS_SQL_INH 0
`define PHX_OPS_RST 16'h0010
`define PHX_OPS_WR_MASK 16'h3fff

// Extended control two fields
`define PHX_EXT_NODE 15
`define PHX_EXT_SWMODE 14
`define PHX_EXT_RFAULT 13
`define PHX_EXT_XAUTO 9
`define PHX_EXT_XFORCE 8
`define PHX_EXT_HIZ 7
`define PHX_EXT_APD 0
`define PHX_EXT_RST 16'h4201
`define PHX_EXT_WR_MASK 16'h1bff
`define PHX_EXT_RO_MASK 16'he400
`define PHX_NODE_MODE 1'h0
`define PHX_SW_MODE 1'h1

// Timing in ns and derived cycle counts
`define PHX_CLK_NS 100
`define PHX_SQE_DLY_NS 600
`define PHX_SQE_LEN_NS 500
`define PHX_JAB_MIN_NS 20000000
`define PHX_SQE_DLY_CYC ((`PHX_SQE_DLY_NS + `PHX_CLK_NS - 1) / `PHX_CLK_NS)
`define PHX_SQE_LEN_CYC ((`PHX_SQE_LEN_NS + `PHX_CLK_NS - 1) / `PHX_CLK_NS)
`define PHX_JAB_CYC (`PHX_JAB_MIN_NS / `PHX_CLK_NS)

`endif

// [hdl/phx_pkg.sv]
// Purpose: Types shared by the 10BT ops / ext control block
// Assumes: Constants live in phx_regs.svh
// Notes: None
package phx_pkg;
    typedef logic [4:0] phx_addr_t;
    typedef logic [15:0] phx_word_t;
    typedef enum logic [1:0] {PHX_LINK_FAIL, PHX_LINK_DATA, PHX_LINK_PASS} phx_link_e;
    typedef enum logic [1:0] {PHX_SQE_IDLE, PHX_SQE_WAIT, PHX_SQE_PULSE} phx_sqe_e;
endpackage

// [hdl/phx_jabber_mon.sv]
// Purpose: Jabber timer, flags activity lasting past the jabber limit
// Assumes: Activity input synchronous to sys_clk
// Notes: Used for both transmit and receive paths
`timescale 1ns/100ps
module phx_jabber_mon #(
    parameter int unsigned JAB_CYC = 200000
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic active,
    input wire logic check_en,
    output logic jabber
);
    logic [17:0] jab_cnt_reg;

    // Length of the current activity burst, saturating
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jab_cnt_reg <= 18'h00000;
        end else if (ce) begin
            if (!active || !check_en) begin
                jab_cnt_reg <= 18'h00000;
            end else if (jab_cnt_reg != 18'(JAB_CYC - 1)) begin
                jab_cnt_reg <= jab_cnt_reg + 18'h00001;
            end
        end
    end

    // Flag held while the burst stays over the limit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jabber <= 1'b0;
        end else if (ce) begin
            jabber <= active && check_en && (jab_cnt_reg == 18'(JAB_CYC - 1));
        end
    end
endmodule

// [hdl/phx_ext_ctrl.sv]
// Purpose: 10BT operations and extended control two registers with their control logic
// Assumes: Management frames already decoded to register strobes; all inputs synchronous
// Notes: Latched status bits clear after the read that returns them, unless their event is present in the read cycle
`timescale 1ns/100ps
`include "phx_regs.svh"

module phx_ext_ctrl #(
    parameter int unsigned JAB_CYC = `PHX_JAB_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire phx_pkg::phx_addr_t mgmt_addr,
    input wire logic mgmt_wr_stb,
    input wire logic mgmt_rd_stb,
    input wire phx_pkg::phx_word_t mgmt_wdata,
    output phx_pkg::phx_word_t mgmt_rdata,
    output logic mgmt_rd_valid,
    input wire logic tx_en,
    input wire logic rx_active,
    input wire logic col_in,
    input wire logic full_duplex,
    input wire logic mode_10bt,
    input wire logic rx_valid_data,
    input wire logic rx_idle,
    input wire logic rx_link_fail,
    input wire logic pol_reversed_det,
    input wire logic remote_fault_in,
    input wire logic crossover_auto_pin,
    input wire logic crossover_auto_result,
    output logic crs,
    output logic col,
    output logic link_pass,
    output logic pol_correct,
    output logic tx_jabber,
    output logic crossover_cross,
    output logic pair_output_hiz,
    output logic tx100_power_down
);
    import phx_pkg::*;

    phx_word_t ops_reg;
    phx_word_t ext_reg;
    logic rjab_latch_reg;
    logic pol_latch_reg;
    logic rx_jab;
    logic ops_rd;
    logic ops_wr;
    logic ext_rd;
    logic ext_wr;
    phx_link_e link_st_reg;
    phx_link_e link_st_next;
    phx_sqe_e sqe_st_reg;
    logic [3:0] sqe_cnt_reg;
    logic sqe_ok;
    logic tx_en_d_reg;

    // Address match shared by read and write decode
    function automatic logic addr_hit(input phx_addr_t a, input phx_addr_t target);
        addr_hit = (a == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    assign ops_rd = mgmt_rd_stb && addr_hit(mgmt_addr, `PHX_OPS_ADDR);
    assign ops_wr = mgmt_wr_stb && addr_hit(mgmt_addr, `PHX_OPS_ADDR);
    assign ext_rd = mgmt_rd_stb && addr_hit(mgmt_addr, `PHX_EXT_ADDR);
    assign ext_wr = mgmt_wr_stb && addr_hit(mgmt_addr, `PHX_EXT_ADDR);

    // Writable operations bits, reserved bits stored as written
    // reserved defaults rely on station
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ops_reg <= `PHX_OPS_RST;
        end else if (ce && ops_wr) begin
            ops_reg <= mgmt_wdata & `PHX_OPS_WR_MASK;
        end
    end

    // Writable extended bits; SQE enabled since inhibit resets to zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_reg <= `PHX_EXT_RST & `PHX_EXT_WR_MASK;
        end else if (ce && ext_wr) begin
            ext_reg <= mgmt_wdata & `PHX_EXT_WR_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Jabber monitors

    phx_jabber_mon #(.JAB_CYC(JAB_CYC)) u_rx_jab (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ce(ce),
        .active(rx_active),
        .check_en(1'b1),
        .jabber(rx_jab)
    );

    phx_jabber_mon #(.JAB_CYC(JAB_CYC)) u_tx_jab (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ce(ce),
        .active(tx_en),
        .check_en(!ops_reg[`PHX_OPS_JAB_INH]),
        .jabber(tx_jabber)
    );

    ////////////////////////////////////////////////////////////////////////
    // Latched status

    // remote jabber latch; set wins over read clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rjab_latch_reg <= 1'b0;
        end else if (ce) begin
            rjab_latch_reg <= (rjab_latch_reg && !ops_rd) || rx_jab;
        end
    end

    // polarity reversal latch; set wins over read clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pol_latch_reg <= 1'b0;
        end else if (ce) begin
            pol_latch_reg <= (pol_latch_reg && !ops_rd) || pol_reversed_det;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    // Registered read answer, old latched values returned
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mgmt_rdata <= 16'h0000;
            mgmt_rd_valid <= 1'b0;
        end else if (ce) begin
            mgmt_rd_valid <= ops_rd || ext_rd;
            if (ops_rd) begin
                mgmt_rdata <= {rjab_latch_reg, pol_latch_reg, ops_reg[13:0]};
            end else if (ext_rd) begin
                mgmt_rdata <= ext_reg | {`PHX_NODE_MODE, `PHX_SW_MODE, remote_fault_in, 13'h0000};
            end else begin
                mgmt_rdata <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link integrity

    // Link state choice from receiver events and inhibits
    always_comb begin
        link_st_next = link_st_reg;
        case (link_st_reg)
            PHX_LINK_FAIL: begin
                if (rx_valid_data) begin
                    link_st_next = ops_reg[`PHX_OPS_SQL_INH] ? PHX_LINK_DATA : PHX_LINK_PASS;
                end
            end
            PHX_LINK_DATA: begin
                if (rx_link_fail) begin
                    link_st_next = PHX_LINK_FAIL;
                end else if (rx_idle) begin
                    link_st_next = PHX_LINK_PASS;
                end
            end
            PHX_LINK_PASS: begin
                if (rx_link_fail) begin
                    link_st_next = PHX_LINK_FAIL;
                end
            end
            default: begin
                link_st_next = PHX_LINK_FAIL;
            end
        endcase
        if (ops_reg[`PHX_OPS_LINK_INH]) begin
            link_st_next = PHX_LINK_PASS;
        end
    end

    // Link state and its registered output
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            link_st_reg <= PHX_LINK_FAIL;
            link_pass <= 1'b0;
        end else if (ce) begin
            link_st_reg <= link_st_next;
            link_pass <= (link_st_next == PHX_LINK_PASS);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // SQE test

    // inhibit bit; full duplex and repeater suppress
    assign sqe_ok = !ops_reg[`PHX_OPS_SQE_INH] && !full_duplex && (`PHX_NODE_MODE == 1'b0);

    // delay then collision pulse after transmit end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_en_d_reg <= 1'b0;
            sqe_st_reg <= PHX_SQE_IDLE;
            sqe_cnt_reg <= 4'h0;
        end else if (ce) begin
            tx_en_d_reg <= tx_en;
            case (sqe_st_reg)
                PHX_SQE_IDLE: begin
                    if (tx_en_d_reg && !tx_en && sqe_ok) begin
                        sqe_st_reg <= PHX_SQE_WAIT;
                        sqe_cnt_reg <= 4'h0;
                    end
                end
                PHX_SQE_WAIT: begin
                    if (!sqe_ok || tx_en) begin
                        sqe_st_reg <= PHX_SQE_IDLE;
                    end else if (sqe_cnt_reg == 4'(`PHX_SQE_DLY_CYC - 1)) begin
                        sqe_st_reg <= PHX_SQE_PULSE;
                        sqe_cnt_reg <= 4'h0;
                    end else begin
                        sqe_cnt_reg <= sqe_cnt_reg + 4'h1;
                    end
                end
                PHX_SQE_PULSE: begin
                    if (!sqe_ok || sqe_cnt_reg == 4'(`PHX_SQE_LEN_CYC - 1)) begin
                        sqe_st_reg <= PHX_SQE_IDLE;
                    end else begin
                        sqe_cnt_reg <= sqe_cnt_reg + 4'h1;
                    end
                end
                default: begin
                    sqe_st_reg <= PHX_SQE_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Media side outputs

    // Carrier sense, collision and polarity correction
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            crs <= 1'b0;
            col <= 1'b0;
            pol_correct <= 1'b0;
        end else if (ce) begin
            crs <= tx_en || rx_active;
            col <= (col_in && !full_duplex) || (sqe_st_reg == PHX_SQE_PULSE && sqe_ok);
            // correction unless inhibited; no crossover term
            pol_correct <= pol_reversed_det && !ops_reg[`PHX_OPS_APOL_INH];
        end
    end

    // Crossover, tri-state and power down controls
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            crossover_cross <= 1'b0;
            pair_output_hiz <= 1'b0;
            tx100_power_down <= 1'b0;
        end else if (ce) begin
            crossover_cross <= (ext_reg[`PHX_EXT_XAUTO] && crossover_auto_pin) ?
                crossover_auto_result : ext_reg[`PHX_EXT_XFORCE];
            pair_output_hiz <= ext_reg[`PHX_EXT_HIZ];
            tx100_power_down <= ext_reg[`PHX_EXT_APD] && mode_10bt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking phx_cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    rjab_latch_a: assert property (ce && rx_jab |=> rjab_latch_reg)
        else $error("remote jabber not latched");
    rjab_hold_a: assert property (ce && rjab_latch_reg && !ops_rd |=> rjab_latch_reg)
        else $error("remote jabber dropped without read");
    read_clear_a: assert property (ce && ops_rd && !rx_jab && !pol_reversed_det
        |=> !rjab_latch_reg && !pol_latch_reg && mgmt_rd_valid)
        else $error("latched bits not cleared after read");
    rd_value_a: assert property (ce && ops_rd |=> mgmt_rdata[`PHX_OPS_RJAB] == $past(rjab_latch_reg)
        && mgmt_rdata[`PHX_OPS_POL] == $past(pol_latch_reg))
        else $error("read lost latched status");
    node_bit_a: assert property (ce && ext_rd |=> !mgmt_rdata[`PHX_EXT_NODE] && mgmt_rdata[`PHX_EXT_SWMODE])
        else $error("node or software bit wrong");
    pol_corr_a: assert property (ce && pol_reversed_det && !ops_reg[`PHX_OPS_APOL_INH] |=> pol_correct)
        else $error("polarity not corrected");
    tx_jab_a: assert property (ce && ops_reg[`PHX_OPS_JAB_INH] |=> !tx_jabber)
        else $error("jabber flagged while inhibited");
    sqe_off_a: assert property (ce && (full_duplex || ops_reg[`PHX_OPS_SQE_INH])
        |=> sqe_st_reg == PHX_SQE_IDLE)
        else $error("SQE test not suppressed");
    sqe_pulse_a: assert property (ce && sqe_st_reg == PHX_SQE_PULSE && sqe_ok
        |=> col)
        else $error("SQE pulse missing on collision");
    link_force_a: assert property (ce && ops_reg[`PHX_OPS_LINK_INH] |=> link_pass)
        else $error("link not forced passed");
    link_idle_a: assert property (ce && link_st_reg == PHX_LINK_FAIL && rx_valid_data
        && ops_reg[`PHX_OPS_SQL_INH] && !ops_reg[`PHX_OPS_LINK_INH] |=> !link_pass)
        else $error("link passed before idle");
    crs_a: assert property (ce && (tx_en || rx_active) |=> crs)
        else $error("carrier sense missing");

    read_clear_c: cover property (rjab_latch_reg && ce && ops_rd ##1 !rjab_latch_reg);
    sqe_c: cover property (sqe_st_reg == PHX_SQE_WAIT ##[1:20] col);
    link_c: cover property (link_st_reg == PHX_LINK_DATA ##[1:20] link_pass);
endmodule

// [tb/phx_sta_model.sv]
// Purpose: Station model driving the decoded register strobes
// Assumes: One request per strobe, answer one cycle later
// Notes: Released bus lines show inverted last values
`timescale 1ns/100ps
module phx_sta_model (
    input wire logic sys_clk,
    output phx_pkg::phx_addr_t mgmt_addr,
    output logic mgmt_wr_stb,
    output logic mgmt_rd_stb,
    output phx_pkg::phx_word_t mgmt_wdata,
    input wire phx_pkg::phx_word_t mgmt_rdata,
    input wire logic mgmt_rd_valid
);
    import phx_pkg::*;
    // Idle bus at time zero
    initial begin
        mgmt_addr = 5'h00;
        mgmt_wr_stb = 1'b0;
        mgmt_rd_stb = 1'b0;
        mgmt_wdata = 16'h0000;
    end
    ////////////////////////////////////////
    // reserved bits at defaults
    function automatic phx_word_t ops_word(input logic [31:0] r);
        return (r[15:0] & 16'h002f) | 16'h0010;
    endfunction
    function automatic phx_word_t ext_word(input logic [31:0] r);
        return r[15:0] & 16'h0381;
    endfunction
    // Write one word
    task automatic wr(input phx_addr_t a, input phx_word_t w);
        @(posedge sys_clk);
        mgmt_addr <= a;
        mgmt_wdata <= w;
        mgmt_wr_stb <= 1'b1;
        @(posedge sys_clk);
        mgmt_wr_stb <= 1'b0;
        mgmt_addr <= ~a;
        mgmt_wdata <= ~w;
    endtask
    // Read one word, answer settled just after the taking edge
    task automatic rd(input phx_addr_t a, output phx_word_t w, output logic v);
        @(posedge sys_clk);
        mgmt_addr <= a;
        mgmt_rd_stb <= 1'b1;
        @(posedge sys_clk);
        mgmt_rd_stb <= 1'b0;
        mgmt_addr <= ~a;
        #1;
        w = mgmt_rdata;
        v = mgmt_rd_valid;
    endtask
endmodule

// [tb/phx_ext_ctrl_tb.sv]
// Purpose: Self-checking bench for the 10BT ops and ext control block
// Assumes: Jabber limit shortened to 20 cycles
// Notes: Register traffic goes through the station model
`timescale 1ns/100ps
`include "phx_regs.svh"
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module phx_ext_ctrl_tb;
import phx_pkg::*;
localparam int JAB = 20;
logic sys_clk = 1'b0;
logic nrst = 1'b0;
logic ce = 1'b1;
logic tx_en = 1'b0, rx_active = 1'b0, col_in = 1'b0, full_duplex = 1'b0, mode_10bt = 1'b1;
logic rx_valid_data = 1'b0, rx_idle = 1'b0, rx_link_fail = 1'b0, pol_reversed_det = 1'b0;
logic remote_fault_in = 1'b0, crossover_auto_pin = 1'b1, crossover_auto_result = 1'b0;
logic mgmt_wr_stb, mgmt_rd_stb, mgmt_rd_valid, crs, col, link_pass, pol_correct, tx_jabber;
logic crossover_cross, pair_output_hiz, tx100_power_down, v;
phx_addr_t mgmt_addr;
phx_word_t mgmt_wdata, mgmt_rdata, d, w, x;
logic [31:0] r;
int err_total = 0;
int compares = 0;
phx_ext_ctrl #(.JAB_CYC(JAB)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .mgmt_addr(mgmt_addr), .mgmt_wr_stb(mgmt_wr_stb), .mgmt_rd_stb(mgmt_rd_stb),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rd_valid(mgmt_rd_valid),
    .tx_en(tx_en), .rx_active(rx_active), .col_in(col_in), .full_duplex(full_duplex),
    .mode_10bt(mode_10bt), .rx_valid_data(rx_valid_data), .rx_idle(rx_idle),
    .rx_link_fail(rx_link_fail), .pol_reversed_det(pol_reversed_det),
    .remote_fault_in(remote_fault_in), .crossover_auto_pin(crossover_auto_pin),
    .crossover_auto_result(crossover_auto_result), .crs(crs), .col(col), .link_pass(link_pass),
    .pol_correct(pol_correct), .tx_jabber(tx_jabber), .crossover_cross(crossover_cross),
    .pair_output_hiz(pair_output_hiz), .tx100_power_down(tx100_power_down));
phx_sta_model u_sta (.sys_clk(sys_clk), .mgmt_addr(mgmt_addr), .mgmt_wr_stb(mgmt_wr_stb),
    .mgmt_rd_stb(mgmt_rd_stb), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rd_valid(mgmt_rd_valid));
// Clock, 100 ns period
initial begin
    forever #50 sys_clk = ~sys_clk;
end
////////////////////////////////////////
// Expected ext read word
function automatic phx_word_t ext_rd(input phx_word_t e, input logic f);
    return (e & 16'h1bff) | {2'b01, f, 13'h0000};
endfunction
// Expected crossover selection
function automatic logic xo(input phx_word_t e, input logic p, input logic a);
    return (e[9] & p) ? a : e[8];
endfunction
// Expected count of collision cycles after a frame
function automatic int sqe_exp(input phx_word_t o, input logic fd);
    return (o[2] | fd) ? 0 : `PHX_SQE_LEN_CYC;
endfunction
task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
endtask
task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
        $display("NO MISMATCHES");
    end else begin
        $display("MISMATCHES SEEN");
    end
    $finish;
endtask
// Short frame, then count collision cycles
task automatic sqe(input phx_word_t o, input logic fd, input string s);
    int n;
    n = 0;
    @(posedge sys_clk);
    tx_en <= 1'b1;
    cyc(3);
    @(posedge sys_clk);
    tx_en <= 1'b0;
    repeat (25) begin
        @(posedge sys_clk);
        #1;
        if (col === 1'b1) n++;
    end
    `CK(s, sqe_exp(o, fd), n)
    $display("test %s done", s);
endtask
////////////////////////////////////////
initial begin
    void'($urandom(32'hdea65ae6));
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    cyc(2);
    `CK("pd rst", 1'b1, tx100_power_down)
    `CK("hiz rst", 1'b0, pair_output_hiz)
    u_sta.rd(`PHX_OPS_ADDR, d, v);
    `CK("ops rst", `PHX_OPS_RST, d)
    `CK("ops valid", 1'b1, v)
    u_sta.rd(`PHX_EXT_ADDR, d, v);
    `CK("ext rst", `PHX_EXT_RST, d)
    u_sta.rd(5'h11, d, v);
    `CK("bad valid", 1'b0, v)
    `CK("bad data", 16'h0000, d)
    $display("test reset done");
    // Enable low freezes outputs
    @(posedge sys_clk);
    ce <= 1'b0;
    tx_en <= 1'b1;
    cyc(3);
    `CK("ce hold", 1'b0, crs)
    @(posedge sys_clk);
    ce <= 1'b1;
    tx_en <= 1'b0;
    cyc(2);
    `CK("ce back", 1'b0, crs)
    $display("test enable done");
    // Random controls, back-to-back writes, readback
    for (int i = 0; i < 8; i++) begin
        r = $urandom;
        w = u_sta.ops_word($urandom);
        x = u_sta.ext_word($urandom);
        @(posedge sys_clk);
        mode_10bt <= r[0];
        remote_fault_in <= r[1];
        crossover_auto_pin <= r[2];
        crossover_auto_result <= r[3];
        u_sta.wr(`PHX_OPS_ADDR, w);
        u_sta.wr(`PHX_EXT_ADDR, x);
        cyc(2);
        `CK("hiz", x[7], pair_output_hiz)
        `CK("pd", x[0] & r[0], tx100_power_down)
        `CK("xover", xo(x, r[2], r[3]), crossover_cross)
        u_sta.rd(`PHX_OPS_ADDR, d, v);
        `CK("ops rb", w, d)
        u_sta.rd(`PHX_EXT_ADDR, d, v);
        `CK("ext rb", ext_rd(x, r[1]), d)
    end
    u_sta.wr(`PHX_OPS_ADDR, 16'h0010);
    $display("test random done");
    // Polarity latch and carrier sense
    @(posedge sys_clk);
    pol_reversed_det <= 1'b1;
    tx_en <= 1'b1;
    cyc(2);
    `CK("pol fix", 1'b1, pol_correct)
    `CK("crs tx", 1'b1, crs)
    u_sta.rd(`PHX_OPS_ADDR, d, v);
    `CK("pol bit", 1'b1, d[14])
    u_sta.rd(`PHX_OPS_ADDR, d, v);
    `CK("pol held", 1'b1, d[14])
    @(posedge sys_clk);
    pol_reversed_det <= 1'b0;
    tx_en <= 1'b0;
    rx_active <= 1'b1;
    cyc(2);
    `CK("crs rx", 1'b1, crs)
    u_sta.rd(`PHX_OPS_ADDR, d, v);
    `CK("pol kept", 1'b1, d[14])
    u_sta.rd(`PHX_OPS_ADDR, d, v);
    `CK("pol clr", 1'b0, d[14])
    @(posedge sys_clk);
    rx_active <= 1'b0;
    pol_reversed_det <= 1'b1;
    u_sta.wr(`PHX_OPS_ADDR, 16'h0018);
    cyc(3);
    `CK("pol inh", 1'b0, pol_correct)
    @(posedge sys_clk);
    pol_reversed_det <= 1'b0;
    u_sta.wr(`PHX_OPS_ADDR, 16'h0010);
    $display("test polarity done");
    // Remote jabber on receive path
    @(posedge sys_clk);
    rx_active <= 1'b1;
    cyc(JAB - 5);
    @(posedge sys_clk);
    rx_active <= 1'b0;
    u_sta.rd(`PHX_OPS_ADDR, d, v);
    `CK("rjab short", 1'b0, d[15])
    @(posedge sys_clk);
    rx_active <= 1'b1;
    cyc(JAB + 4);
    `CK("rjab no act", 1'b0, tx_jabber)
    @(posedge sys_clk);
    rx_active <= 1'b0;
    u_sta.rd(`PHX_OPS_ADDR, d, v);
    `CK("rjab set", 1'b1, d[15])
    u_sta.rd(`PHX_OPS_ADDR, d, v);
    `CK("rjab clr", 1'b0, d[15])
    // Transmit jabber, bounded wait
    @(posedge sys_clk);
    tx_en <= 1'b1;
    for (int k = 0; k < JAB + 10 && tx_jabber !== 1'b1; k++) cyc(1);
    `CK("tx jab", 1'b1, tx_jabber)
    if (tx_jabber !== 1'b1) stop_test;
    @(posedge sys_clk);
    tx_en <= 1'b0;
    u_sta.wr(`PHX_OPS_ADDR, 16'h0030);
    @(posedge sys_clk);
    tx_en <= 1'b1;
    cyc(JAB + 5);
    `CK("tx jab inh", 1'b0, tx_jabber)
    @(posedge sys_clk);
    tx_en <= 1'b0;
    u_sta.wr(`PHX_OPS_ADDR, 16'h0010);
    $display("test jabber done");
    // Collision test pulse
    sqe(16'h0010, 1'b0, "sqe on");
    u_sta.wr(`PHX_OPS_ADDR, 16'h0014);
    sqe(16'h0014, 1'b0, "sqe inh");
    u_sta.wr(`PHX_OPS_ADDR, 16'h0010);
    @(posedge sys_clk);
    full_duplex <= 1'b1;
    sqe(16'h0010, 1'b1, "sqe fdx");
    u_sta.wr(`PHX_OPS_ADDR, 16'h0014);
    u_sta.rd(`PHX_OPS_ADDR, d, v);
    `CK("sqe bit", 16'h0014, d & 16'h3fff)
    @(posedge sys_clk);
    col_in <= 1'b1;
    cyc(2);
    `CK("col fdx", 1'b0, col)
    @(posedge sys_clk);
    full_duplex <= 1'b0;
    cyc(2);
    `CK("col hdx", 1'b1, col)
    @(posedge sys_clk);
    col_in <= 1'b0;
    $display("test collision done");
    // Link integrity
    u_sta.wr(`PHX_OPS_ADDR, 16'h0012);
    @(posedge sys_clk);
    rx_link_fail <= 1'b1;
    cyc(3);
    `CK("link forced", 1'b1, link_pass)
    u_sta.wr(`PHX_OPS_ADDR, 16'h0010);
    cyc(3);
    `CK("link fail", 1'b0, link_pass)
    @(posedge sys_clk);
    rx_link_fail <= 1'b0;
    rx_valid_data <= 1'b1;
    @(posedge sys_clk);
    rx_valid_data <= 1'b0;
    cyc(2);
    `CK("link data", 1'b1, link_pass)
    u_sta.wr(`PHX_OPS_ADDR, 16'h0011);
    @(posedge sys_clk);
    rx_link_fail <= 1'b1;
    @(posedge sys_clk);
    rx_link_fail <= 1'b0;
    rx_valid_data <= 1'b1;
    @(posedge sys_clk);
    rx_valid_data <= 1'b0;
    cyc(2);
    `CK("sql data", 1'b0, link_pass)
    @(posedge sys_clk);
    rx_idle <= 1'b1;
    @(posedge sys_clk);
    rx_idle <= 1'b0;
    cyc(2);
    `CK("sql idle", 1'b1, link_pass)
    $display("test link done");
    stop_test;
end
endmodule
